// >>> common/cbs_params.svh
// Named constants for the bit synchronizer.
`ifndef CBS_PARAMS_SVH
`define CBS_PARAMS_SVH
`define CBS_SEG_W      4
`define CBS_BRP_W      6
`define CBS_SJW_W      2
`define CBS_SEG_W_MIN  2
`define CBS_RECESSIVE  1'b1
`define CBS_CNT_ZERO   1'b0
`endif

// >>> common/cbs_pkg.sv
// Types shared by the bit synchronizer modules.
package cbs_pkg;
  typedef enum logic [2:0] {
    CBS_SEG_SYNC = 3'h1,
    CBS_SEG_T1   = 3'h2,
    CBS_SEG_T2   = 3'h4
  } cbs_seg_e;
endpackage

// >>> common/cbs_tq_if.sv
// Carrier between the quantum divider and the bit timing logic.
interface cbs_tq_if #(parameter int BRP_W = 6);
  logic [BRP_W-1:0] brp;
  logic             tick;
  modport div  (input brp, output tick);
  modport user (output brp, input tick);
endinterface

// >>> logic/cbs_bit_sync.sv
// Bit timing and edge synchronization for a CAN receiver.
`include "cbs_params.svh"
module cbs_bit_sync #(
  parameter int SEG_W = `CBS_SEG_W,
  parameter int BRP_W = `CBS_BRP_W
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rstn_i,
  input  wire logic                    rx_i,
  input  wire logic                    bus_idle_i,
  input  wire logic                    tx_dominant_i,
  input  wire logic [BRP_W-1:0]        brp_i,
  input  wire logic [SEG_W-1:0]        prop_seg_i,
  input  wire logic [SEG_W-1:0]        phase1_i,
  input  wire logic [SEG_W-1:0]        phase2_i,
  input  wire logic [`CBS_SJW_W-1:0]   jump_width_limit_i,
  output logic                         tq_o,
  output logic                         sample_o,
  output logic                         sampled_bit_o,
  output logic                         hard_sync_o,
  output logic                         resync_o,
  output cbs_pkg::cbs_seg_e            seg_o
);
  import cbs_pkg::*;

  localparam int CW = SEG_W + 2;

  // Reject widths too narrow to hold a useful segment.
  if (SEG_W < `CBS_SEG_W_MIN) begin : g_chk
    $error("SEG_W too small for bit timing");
  end

  cbs_tq_if #(.BRP_W(BRP_W)) tq ();

  cbs_tq_div #(.BRP_W(BRP_W)) u_div (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .tq        (tq.div)
  );

  assign tq.brp = brp_i;
  assign tq_o   = tq.tick;

  cbs_seg_e      seg_reg,   seg_next;
  logic [CW-1:0] cnt_reg,   cnt_next;
  logic [CW-1:0] t1_len_reg, t1_len_next;
  logic [CW-1:0] t2_len_reg, t2_len_next;
  logic          done_reg,  done_next;
  logic          smp_reg,   smp_next;
  logic          rxp_reg,   rxp_next;
  logic          smpp_reg,  smpp_next;
  logic          hard_reg,  hard_next;
  logic          rsy_reg,   rsy_next;
  logic [CW-1:0] jump_width_limit;
  logic [CW-1:0] t1_nom;
  logic [CW-1:0] t2_nom;
  logic [CW-1:0] err_mag;
  logic          fall_ok;
  logic          small_err;

  // Jump width 1..4 quanta, nominal segment lengths.
  always_comb begin
    jump_width_limit    = CW'(jump_width_limit_i) + 1'b1;
    t1_nom = CW'(prop_seg_i) + CW'(phase1_i);
    t2_nom = CW'(phase2_i);
  end

  // Qualify edges: recessive to dominant, previous sample recessive.
  always_comb begin
    fall_ok = tq.tick && rxp_reg && !rx_i
              && (smp_reg != rx_i);
    err_mag = '0;
    unique case (seg_reg)
      CBS_SEG_SYNC: err_mag = '0;
      CBS_SEG_T1:   err_mag = cnt_reg + 1'b1;
      CBS_SEG_T2:   err_mag = t2_len_reg - cnt_reg;
    endcase
    small_err = (err_mag <= jump_width_limit);
  end

  // Next-state logic for segment sequencing and synchronization.
  always_comb begin
    seg_next    = seg_reg;
    cnt_next    = cnt_reg;
    t1_len_next = t1_len_reg;
    t2_len_next = t2_len_reg;
    done_next   = done_reg;
    smp_next    = smp_reg;
    rxp_next    = rxp_reg;
    smpp_next   = 1'b0;
    hard_next   = 1'b0;
    rsy_next    = 1'b0;
    if (tq.tick) begin
      rxp_next = rx_i;
      unique case (seg_reg)
        CBS_SEG_SYNC: begin
          seg_next = CBS_SEG_T1;
          cnt_next = '0;
        end
        CBS_SEG_T1: begin
          if (cnt_reg + 1'b1 >= t1_len_reg) begin
            seg_next  = CBS_SEG_T2;
            cnt_next  = '0;
            smp_next  = rx_i;
            smpp_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        CBS_SEG_T2: begin
          if (cnt_reg + 1'b1 >= t2_len_reg) begin
            seg_next    = CBS_SEG_SYNC;
            cnt_next    = '0;
            done_next   = 1'b0;
            t1_len_next = t1_nom;
            t2_len_next = t2_nom;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      endcase
      if (fall_ok && !done_reg) begin
        if (bus_idle_i || seg_reg == CBS_SEG_SYNC || small_err) begin
          if (bus_idle_i || seg_reg != CBS_SEG_T1 || !tx_dominant_i) begin
            // Edge quantum becomes the sync segment of a fresh bit.
            seg_next    = CBS_SEG_T1;
            cnt_next    = '0;
            smp_next    = smp_reg;
            smpp_next   = 1'b0;
            done_next   = 1'b1;
            t1_len_next = t1_nom;
            t2_len_next = t2_nom;
            hard_next   = bus_idle_i;
            rsy_next    = !bus_idle_i;
          end
        end else if (seg_reg == CBS_SEG_T1) begin
          if (!tx_dominant_i) begin
            // Stretch phase 1 and keep counting in it.
            t1_len_next = t1_len_reg + jump_width_limit;
            seg_next    = CBS_SEG_T1;
            cnt_next    = cnt_reg + 1'b1;
            smp_next    = smp_reg;
            smpp_next   = 1'b0;
            done_next   = 1'b1;
            rsy_next    = 1'b1;
          end
        end else begin
          // Shrink phase 2, ending the bit now if already past the new end.
          t2_len_next = t2_len_reg - jump_width_limit;
          rsy_next    = 1'b1;
          if (cnt_reg + 1'b1 >= t2_len_reg - jump_width_limit) begin
            seg_next    = CBS_SEG_SYNC;
            cnt_next    = '0;
            done_next   = 1'b0;
            t1_len_next = t1_nom;
            t2_len_next = t2_nom;
          end else begin
            done_next = 1'b1;
          end
        end
      end
    end
  end

  // State registers.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      seg_reg    <= CBS_SEG_SYNC;
      cnt_reg    <= '0;
      t1_len_reg <= '0;
      t2_len_reg <= '0;
      done_reg   <= 1'b0;
      smp_reg    <= `CBS_RECESSIVE;
      rxp_reg    <= `CBS_RECESSIVE;
      smpp_reg   <= 1'b0;
      hard_reg   <= 1'b0;
      rsy_reg    <= 1'b0;
    end else begin
      seg_reg    <= seg_next;
      cnt_reg    <= cnt_next;
      t1_len_reg <= t1_len_next;
      t2_len_reg <= t2_len_next;
      done_reg   <= done_next;
      smp_reg    <= smp_next;
      rxp_reg    <= rxp_next;
      smpp_reg   <= smpp_next;
      hard_reg   <= hard_next;
      rsy_reg    <= rsy_next;
    end
  end

  // Outputs other than tq_o come straight from registers.
  always_comb begin
    sample_o      = smpp_reg;
    sampled_bit_o = smp_reg;
    hard_sync_o   = hard_reg;
    resync_o      = rsy_reg;
    seg_o         = seg_reg;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  logic sync_any;
  assign sync_any = hard_next || rsy_next;

  property p_hard_idle;
    hard_next |-> bus_idle_i && fall_ok;
  endproperty
  a_hard_idle: assert property (p_hard_idle) else $error("hard sync without idle edge");

  property p_hard_restart;
    hard_sync_o |-> seg_reg == CBS_SEG_T1 && cnt_reg == `CBS_CNT_ZERO;
  endproperty
  a_hard_restart: assert property (p_hard_restart) else $error("hard sync did not restart");

  property p_no_second;
    done_reg |-> !sync_any;
  endproperty
  a_no_second: assert property (p_no_second) else $error("second sync in one bit");

  // Phase 1 may never grow past its nominal length by more than the widest jump.
  property p_sjw_range;
    jump_width_limit >= CW'(1) && jump_width_limit <= CW'(4) && t1_len_reg <= t1_nom + CW'(4);
  endproperty
  a_sjw_range: assert property (p_sjw_range) else $error("jump width out of range");

  property p_fall_only;
    sync_any |-> rxp_reg && !rx_i && smp_reg;
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("sync on wrong edge");

  property p_small_restart;
    (rsy_next && small_err) |=> seg_reg == CBS_SEG_T1 && cnt_reg == `CBS_CNT_ZERO;
  endproperty
  a_small_restart: assert property (p_small_restart) else $error("small error not restarted");

  property p_stretch;
    (rsy_next && !small_err && seg_reg == CBS_SEG_T1) |=> t1_len_reg == $past(t1_len_reg) + $past(jump_width_limit);
  endproperty
  a_stretch: assert property (p_stretch) else $error("phase 1 not stretched by jump width");

  property p_shrink;
    (rsy_next && !small_err && seg_reg == CBS_SEG_T2 && !(seg_next == CBS_SEG_SYNC))
      |=> t2_len_reg == $past(t2_len_reg) - $past(jump_width_limit);
  endproperty
  a_shrink: assert property (p_shrink) else $error("phase 2 not shrunk by jump width");

  property p_tx_dom;
    (rsy_next && seg_reg == CBS_SEG_T1) |-> !tx_dominant_i;
  endproperty
  a_tx_dom: assert property (p_tx_dom) else $error("positive resync while sending dominant");

  property p_nominal;
    (tq.tick && seg_reg == CBS_SEG_T2 && seg_next == CBS_SEG_SYNC) |=> t2_len_reg == t2_nom;
  endproperty
  a_nominal: assert property (p_nominal) else $error("adjustment leaked into next bit");
endmodule

// >>> logic/cbs_tq_div.sv
// Time quantum prescaler producing a one-cycle enable per quantum.
`include "cbs_params.svh"
module cbs_tq_div #(parameter int BRP_W = `CBS_BRP_W) (
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  cbs_tq_if.div     tq
);
  logic [BRP_W-1:0] cnt_reg;
  logic [BRP_W-1:0] cnt_next;

  // Count up to the prescale value, then wrap and emit a tick.
  always_comb begin
    tq.tick = (cnt_reg >= tq.brp);
    cnt_next = tq.tick ? '0 : cnt_reg + 1'b1;
  end

  // Register the prescale counter.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// >>> verification/cbs_node_model.sv
// Behavioural model of another node driving the shared bus level.
module cbs_node_model (
  input  wire logic ref_clk_i,
  output logic      rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl_reg = 1'b1;
  // A released bus is pulled to the recessive level by termination.
  assign rx_o = lvl_reg;
  // Pull the bus dominant; callers change it just after a falling edge.
  task automatic set_dom();
    lvl_reg = 1'b0;
  endtask
  // Let go of the bus so it returns to recessive.
  task automatic release_bus();
    lvl_reg = 1'b1;
  endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the bit synchronizer with tied nominal segments.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cbs_pkg::*;
  logic       ref_clk_i = 1'b0;
  logic       rstn_i    = 1'b0;
  logic       bus_idle  = 1'b0;
  logic       tx_dom    = 1'b0;
  logic [1:0] jump_width_limit       = 2'h0;
  logic       rx;
  logic       tq;
  logic       smp;
  logic       sbit;
  logic       hs;
  logic       rs;
  cbs_seg_e   seg;
  int         n_fail    = 0;
  int         n_checks  = 0;

  // Free-running 125 MHz clock.
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  cbs_node_model cbs_node_model_i (.ref_clk_i(ref_clk_i), .rx_o(rx));

  // Bit is 1 sync, 6 in phase segment 1 and 4 in phase segment 2.
  cbs_bit_sync cbs_bit_sync_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .rx_i(rx), .bus_idle_i(bus_idle),
    .tx_dominant_i(tx_dom), .brp_i(6'h00), .prop_seg_i(4'h2), .phase1_i(4'h4), .phase2_i(4'h4),
    .jump_width_limit_i(jump_width_limit), .tq_o(tq), .sample_o(smp), .sampled_bit_o(sbit), .hard_sync_o(hs),
    .resync_o(rs), .seg_o(seg));

  task automatic test_done();
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // Find the next sync segment within 30 cycles, under three bit times.
  task automatic wait_sync();
    int k;
    k = 0;
    ticks(1);
    while (seg !== CBS_SEG_SYNC && k < 30) begin
      ticks(1);
      k++;
    end
    chk(k < 30, "sync segment not reached");
  endtask

  // Count cycles to the sample pulse and note any resync on the way.
  task automatic until_sample(output int n, output logic r);
    n = 0;
    r = 1'b0;
    do begin
      ticks(1);
      n++;
      r = r | rs;
    end while (smp !== 1'b1 && n < 30);
  endtask

  // Release the bus; the rising edge must never synchronize.
  task automatic settle();
    cbs_node_model_i.release_bus();
    bus_idle = 1'b0;
    tx_dom = 1'b0;
    for (int k = 0; k < 36; k++) begin
      ticks(1);
      chk(hs === 1'b0 && rs === 1'b0, "sync on rising edge");
      chk(tq === 1'b1, "quantum tick missing at unit prescale");
    end
  endtask

  // Idle edge restarts the bit; a second edge in that bit is ignored.
  task automatic t_hard();
    int n;
    logic r;
    jump_width_limit = 2'h0;
    bus_idle = 1'b1;
    wait_sync();
    ticks(3);
    cbs_node_model_i.set_dom();
    ticks(1);
    chk(hs === 1'b1 && rs === 1'b0, "no hard sync at idle");
    chk(seg === CBS_SEG_T1, "bit not restarted");
    bus_idle = 1'b0;
    cbs_node_model_i.release_bus();
    ticks(1);
    cbs_node_model_i.set_dom();
    until_sample(n, r);
    chk(r === 1'b0 && n == 5, "second sync in bit");
    ticks(1);
    chk(sbit === 1'b0, "sampled value wrong");
    settle();
  endtask

  // Error within the jump width restarts the bit.
  task automatic t_small();
    int n;
    logic r;
    jump_width_limit = 2'h3;
    wait_sync();
    ticks(3);
    cbs_node_model_i.set_dom();
    until_sample(n, r);
    chk(r === 1'b1 && n == 7, "small error restart");
    settle();
  endtask

  // Late edge stretches segment 1 by the jump width unless sending dominant.
  task automatic t_pos(input logic tx);
    int n;
    logic r;
    for (int j = 0; j < 4; j++) begin
      jump_width_limit = j[1:0];
      tx_dom = tx;
      wait_sync();
      ticks(6);
      cbs_node_model_i.set_dom();
      until_sample(n, r);
      chk(r === !tx, "resync flag");
      chk(n == (tx ? 1 : 2 + j), "phase 1 length");
      settle();
    end
  endtask

  // Edge after the sample point shortens segment 2, then nominal returns.
  task automatic t_neg();
    int n;
    logic r;
    for (int j = 0; j < 3; j++) begin
      jump_width_limit = j[1:0];
      wait_sync();
      ticks(7);
      cbs_node_model_i.set_dom();
      ticks(1);
      chk(rs === 1'b1, "no resync after sample point");
      n = 1;
      while (seg !== CBS_SEG_SYNC && n < 20) begin
        ticks(1);
        n++;
      end
      chk(n == 3 - j, "phase 2 length");
      until_sample(n, r);
      chk(n == 7 && r === 1'b0, "length not restored");
      settle();
    end
  endtask

  // Reset for 16 cycles, then run every scenario.
  initial begin
    ticks(16);
    rstn_i = 1'b1;
    settle();
    t_hard();
    t_small();
    t_pos(1'b0);
    t_pos(1'b1);
    t_neg();
    test_done();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    ticks(5000);
    n_fail++;
    test_done();
  end
endmodule
